// File: pcl_cfg_loader.sv
// Configuration loader: working RAM, data flash, init and checksum
`timescale 1ns/1ns

// Overview of operation
// - Unconfigured part: pins high impedance, no sequencing
// - Bus commands write parameters into working RAM
// - Store-all copies whole RAM into flash
// - Direct flash image leaves current behaviour alone
// - RAM parameter changes act at once
// - Pin role changes need a reset
// - Old configuration runs until next reset
// - Test port refuses configuration loads
// - Reset starts 40 ms init, pins high impedance
// - Bad checksum: discard config, alert, flag
module pcl_cfg_loader import pcl_pkg::*; #(
    parameter int unsigned INIT_CYCLES = INIT_CYC
) (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic por_n,
    // Management command port
    input wire logic cmd_valid,
    input wire pcl_cmd_t cmd,
    output logic cmd_ready,
    // Active configuration read
    input wire logic [ADDR_W-1:0] cfg_rd_addr,
    output logic [DATA_W-1:0] cfg_rd_data,
    // Test access port
    input wire logic tap_cfg_req,
    output logic tap_cfg_reject,
    // Pins and status
    output logic [PIN_W-1:0] io_oe,
    output logic seq_run,
    output logic init_busy,
    output logic cfg_bad,
    output logic bus_alert_output_o,
    output logic bus_alert_output_oe
);

    localparam int CNT_W = $clog2(INIT_CYCLES + 1);
    localparam int STORE_LAT = CFG_WORDS + 2;

    // ************************************************************
    // Reset and input synchronisers
    // ************************************************************
    logic [1:0] rst_sync_r;
    logic [1:0] por_sync_r;
    logic [1:0] tap_sync_r;
    logic rst_sys_n;
    logic rst_por_n;
    logic any_rst_n;

    assign any_rst_n = rst_n & por_n;
    assign rst_sys_n = rst_sync_r[1];
    assign rst_por_n = por_sync_r[1];

    always_ff @(posedge clk_sys or negedge any_rst_n) begin
        if (!any_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            por_sync_r <= 2'h0;
        end else begin
            por_sync_r <= {por_sync_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tap_sync_r <= 2'h0;
        end else begin
            tap_sync_r <= {tap_sync_r[0], tap_cfg_req};
        end
    end

    function automatic logic [DATA_W-1:0] add_w(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b
    );
        return a + b;
    endfunction

    // ************************************************************
    // State and control
    // ************************************************************
    pcl_state_t st_r;
    logic [ADDR_W-1:0] idx_r;
    logic [DATA_W-1:0] sum_r;
    logic [CNT_W-1:0] init_cnt_r;
    logic [DATA_W-1:0] ram_r [CFG_WORDS];
    logic [DATA_W-1:0] flash_r [CFG_WORDS + 1];
    logic blank_r;
    logic configured_r;
    logic bad_r;
    logic [PIN_W-1:0] pin_fn_r;
    logic tap_rej_r;
    logic [DATA_W-1:0] rd_r;
    logic cmd_take;
    logic load_act;
    logic copy_act;
    logic init_done;
    logic sum_ok;
    logic [DATA_W-1:0] flash_word;
    logic [DATA_W-1:0] ram_word;
    logic [DATA_W-1:0] ram_at_cmd;

    assign cmd_ready = (st_r == ST_RUN);
    assign cmd_take = cmd_valid && cmd_ready;
    assign load_act = (st_r == ST_INIT) && (idx_r < CFG_WORDS);
    assign copy_act = (st_r == ST_STORE) && (idx_r < CFG_WORDS);
    assign init_done = (st_r == ST_INIT)
        && (init_cnt_r == CNT_W'(INIT_CYCLES - 1));
    assign flash_word = flash_r[idx_r];
    assign ram_word = (idx_r < CFG_WORDS) ? ram_r[idx_r] : SUM_RST;
    assign ram_at_cmd = (cmd.addr < CFG_WORDS) ? ram_r[cmd.addr] : SUM_RST;
    assign sum_ok = (sum_r == flash_r[CFG_WORDS]);

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            st_r <= ST_INIT;
            idx_r <= '0;
            sum_r <= SUM_RST;
            init_cnt_r <= '0;
        end else begin
            case (st_r)
                ST_INIT: begin
                    init_cnt_r <= init_cnt_r + 1'b1;
                    if (load_act) begin
                        idx_r <= idx_r + 1'b1;
                        sum_r <= add_w(sum_r, flash_word);
                    end
                    if (init_done) begin
                        idx_r <= '0;
                        if (!blank_r && !sum_ok) begin
                            st_r <= ST_WIPE;
                        end else begin
                            st_r <= ST_RUN;
                        end
                    end
                end
                ST_WIPE: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == CFG_WORDS - 1'b1) begin
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cmd_take && cmd.op == OP_STORE_ALL) begin
                        st_r <= ST_STORE;
                        idx_r <= '0;
                        sum_r <= SUM_RST;
                    end
                end
                ST_STORE: begin
                    if (copy_act) begin
                        idx_r <= idx_r + 1'b1;
                        sum_r <= add_w(sum_r, ram_word);
                    end else begin
                        st_r <= ST_RUN;
                    end
                end
                default: begin
                    st_r <= ST_INIT;
                end
            endcase
        end
    end

    // ************************************************************
    // Working RAM
    // ************************************************************
    // Commands land here and take effect without any commit step
    always_ff @(posedge clk_sys) begin
        if (load_act) begin
            ram_r[idx_r] <= flash_word;
        end else if (st_r == ST_WIPE) begin
            ram_r[idx_r] <= SUM_RST;
        end else if (cmd_take && cmd.op == OP_RAM_WR
                     && cmd.addr < CFG_WORDS) begin
            ram_r[cmd.addr] <= cmd.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            rd_r <= SUM_RST;
        end else begin
            rd_r <= (cfg_rd_addr < CFG_WORDS) ? ram_r[cfg_rd_addr]
                : SUM_RST;
        end
    end

    // ************************************************************
    // Data flash
    // ************************************************************
    // Image writes never touch RAM; they wait for the next reload
    always_ff @(posedge clk_sys) begin
        if (copy_act) begin
            flash_r[idx_r] <= ram_word;
        end else if (st_r == ST_STORE) begin
            flash_r[CFG_WORDS] <= sum_r;
        end else if (cmd_take && cmd.op == OP_FLASH_WR) begin
            flash_r[cmd.addr] <= cmd.data;
        end
    end

    // Only power-on gives a blank, factory-state flash
    always_ff @(posedge clk_sys or negedge rst_por_n) begin
        if (!rst_por_n) begin
            blank_r <= 1'b1;
        end else if ((st_r == ST_STORE && !copy_act)
                     || (cmd_take && cmd.op == OP_FLASH_WR)) begin
            blank_r <= 1'b0;
        end
    end

    // ************************************************************
    // Pin roles, status and alert
    // ************************************************************
    // Pin roles are sampled once per reset, so a live edit cannot
    // tear down a rail that feeds this device mid-programming
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pin_fn_r <= PIN_FN_RST;
        end else if (init_done && !blank_r && sum_ok) begin
            pin_fn_r <= ram_r[PIN_FN_IDX];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            configured_r <= 1'b0;
            bad_r <= 1'b0;
        end else begin
            if (init_done && !blank_r) begin
                configured_r <= sum_ok;
                bad_r <= !sum_ok;
            end else if (st_r == ST_STORE && !copy_act) begin
                configured_r <= 1'b1;
            end
        end
    end

    // Any configuration attempt through the test port is dropped
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tap_rej_r <= 1'b0;
        end else begin
            tap_rej_r <= tap_sync_r[1];
        end
    end

    assign io_oe = pin_fn_r;
    assign seq_run = configured_r;
    assign init_busy = (st_r == ST_INIT);
    assign cfg_bad = bad_r;
    assign cfg_rd_data = rd_r;
    assign tap_cfg_reject = tap_rej_r;
    assign bus_alert_output_o = 1'b0;
    assign bus_alert_output_oe = bad_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sys_n);

    a_hiz_in_init: assert property (init_busy |-> io_oe == '0)
        else $error("pins driven during init");
    a_init_length: assert property (init_busy && !init_done |=> init_busy
        ##0 init_cnt_r == $past(init_cnt_r) + 1'b1)
        else $error("init ended early");
    a_hiz_factory: assert property (!seq_run |-> io_oe == '0)
        else $error("pins driven while unconfigured");
    a_ram_write: assert property (cmd_take && cmd.op == OP_RAM_WR
        && cmd.addr < CFG_WORDS |=> ram_r[$past(cmd.addr)] == $past(cmd.data))
        else $error("parameter not placed in RAM");
    a_live_update: assert property (cmd_take && cmd.op == OP_RAM_WR
        && cmd.addr < CFG_WORDS && cmd.addr == cfg_rd_addr
        ##1 $stable(cfg_rd_addr) |=> cfg_rd_data == $past(cmd.data, 2))
        else $error("RAM change not live");
    a_store_copy: assert property (copy_act
        |=> flash_r[$past(idx_r)] == $past(ram_word))
        else $error("store copy mismatch");
    a_store_done: assert property (cmd_take && cmd.op == OP_STORE_ALL
        |=> !cmd_ready ##16 cmd_ready && !blank_r)
        else $error("store length wrong");
    a_image_defer: assert property (cmd_take && cmd.op == OP_FLASH_WR
        && cmd.addr < CFG_WORDS |=> ram_r[$past(cmd.addr)] == $past(ram_at_cmd))
        else $error("image altered RAM");
    a_old_config: assert property (cmd_take && cmd.op == OP_FLASH_WR
        |=> $stable(io_oe) && $stable(seq_run))
        else $error("image changed behaviour");
    a_pin_latched: assert property (!init_busy && $past(!init_busy)
        |-> $stable(pin_fn_r))
        else $error("pin roles changed without reset");
    a_tap_reject: assert property ($rose(tap_sync_r[1])
        |=> tap_cfg_reject && $stable(st_r))
        else $error("test port request not refused");
    a_bad_alert: assert property (init_done && !blank_r && !sum_ok
        |=> cfg_bad && bus_alert_output_oe && !seq_run && st_r == ST_WIPE)
        else $error("bad checksum not flagged");
    a_reload_word: assert property (load_act
        |=> ram_r[$past(idx_r)] == $past(flash_word))
        else $error("reload word mismatch");

    c_store_all: cover property (cmd_take && cmd.op == OP_STORE_ALL);
    c_image_write: cover property (cmd_take && cmd.op == OP_FLASH_WR);
    c_bad_sum: cover property (init_done && !blank_r && !sum_ok);
    c_good_boot: cover property (init_done && !blank_r && sum_ok);

endmodule

// File: pcl_pkg.sv
// Shared constants and types of the configuration loader
package pcl_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PIN_W = 16;
    // Config words in RAM; flash holds one more word for the checksum
    localparam logic [ADDR_W-1:0] CFG_WORDS = 4'hf;
    // Word that holds the pin output roles
    localparam logic [ADDR_W-1:0] PIN_FN_IDX = 4'h0;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [PIN_W-1:0] PIN_FN_RST = 16'h0000;
    localparam logic [DATA_W-1:0] SUM_RST = 16'h0000;
    localparam int unsigned INIT_TIME_MS = 40;
    localparam int unsigned CLK_FREQ_HZ = 10_000_000;
    localparam int unsigned INIT_CYC = INIT_TIME_MS * (CLK_FREQ_HZ / 1000);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        OP_RAM_WR = 2'h0,
        OP_STORE_ALL = 2'h1,
        OP_FLASH_WR = 2'h2,
        OP_NONE = 2'h3
    } pcl_op_t;

    typedef struct packed {
        pcl_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } pcl_cmd_t;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_WIPE,
        ST_RUN,
        ST_STORE
    } pcl_state_t;

endpackage

// File: pcl_host_model.sv
// Management host model that issues commands to the loader
`timescale 1ns/1ns
module pcl_host_model import pcl_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Command port
    output logic cmd_valid,
    output pcl_cmd_t cmd,
    input wire logic cmd_ready
);
    // ************************************************************
    // Command issue
    // ************************************************************
    initial begin
        cmd_valid = 1'b0;
        cmd = '{OP_NONE, 4'h0, 16'h0000};
    end

    // Sole bus owner, one powered device at a time
    task automatic send(input pcl_op_t op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input int slow);
        int n;
        n = 0;
        repeat (slow) @(posedge clk_sys);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= '{op, a, d};
        @(negedge clk_sys);
        // Held through init, wipe and store
        while (cmd_ready !== 1'b1 && n < 1000) begin
            n++;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // Released lines never keep the stale word
        cmd <= pcl_cmd_t'(~{op, a, d});
    endtask
endmodule

// File: test_pmbus_config_programming.sv
// Self-checking testbench of the configuration loader
`timescale 1ns/1ns
module test_pmbus_config_programming import pcl_pkg::*;;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam int unsigned INIT_SIM = 32;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic cmd_valid, cmd_ready, tap_cfg_reject, seq_run, init_busy;
    logic cfg_bad, alert_o, alert_oe;
    pcl_cmd_t cmd;
    logic [ADDR_W-1:0] cfg_rd_addr = 4'h0;
    logic [DATA_W-1:0] cfg_rd_data;
    logic tap_cfg_req = 1'b0;
    logic [PIN_W-1:0] io_oe;
    logic [DATA_W-1:0] exp_ram [0:14];
    int num_errors = 0;
    int comparisons = 0;

    always #50 clk_sys = ~clk_sys;

    pcl_cfg_loader #(.INIT_CYCLES(INIT_SIM)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
        .tap_cfg_req(tap_cfg_req), .tap_cfg_reject(tap_cfg_reject),
        .io_oe(io_oe), .seq_run(seq_run), .init_busy(init_busy),
        .cfg_bad(cfg_bad), .bus_alert_output_o(alert_o),
        .bus_alert_output_oe(alert_oe));

    pcl_host_model host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(string nm, logic e, logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [15:0] ram_sum();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 15; i++) s = s + exp_ram[i];
        return s;
    endfunction

    task automatic do_reset(input logic cold);
        int n;
        n = 0;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        por_n <= ~cold;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("init_busy in reset", 1'b1, init_busy);
        chk_word("io_oe in reset", 16'h0000, io_oe);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(negedge clk_sys);
        while (init_busy === 1'b1 && n < 200) begin
            if (io_oe !== 16'h0000) chk_word("io_oe init", 16'h0000, io_oe);
            n++;
            @(negedge clk_sys);
        end
        chk_bit("init length", 1'b1, n >= INIT_SIM && n < 200);
    endtask

    task automatic read_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        cfg_rd_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk_word("cfg_rd_data", e, cfg_rd_data);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_factory();
        do_reset(1'b1);
        chk_bit("seq_run factory", 1'b0, seq_run);
        chk_word("io_oe factory", 16'h0000, io_oe);
        chk_bit("alert factory", 1'b0, alert_oe);
    endtask

    task automatic t_write();
        for (int i = 0; i < 15; i++) begin
            exp_ram[i] = (i == 0) ? 16'h00f0 : 16'h1000 + 16'(i);
            host_u.send(OP_RAM_WR, 4'(i), exp_ram[i], i % 3);
        end
        for (int i = 0; i < 15; i++) read_chk(4'(i), exp_ram[i]);
        host_u.send(OP_NONE, 4'h2, 16'hdead, 0);
        host_u.send(OP_RAM_WR, 4'hf, 16'hbeef, 0);
        read_chk(4'h2, exp_ram[2]);
        read_chk(4'hf, 16'h0000);
        chk_word("io_oe before reset", 16'h0000, io_oe);
    endtask

    task automatic t_store();
        int n;
        n = 0;
        host_u.send(OP_STORE_ALL, 4'h0, 16'h0000, 0);
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 100) begin
            n++;
            @(negedge clk_sys);
        end
        chk_word("store busy cycles", 16'd16, 16'(n));
        chk_bit("seq_run stored", 1'b1, seq_run);
        chk_word("io_oe stored", 16'h0000, io_oe);
        do_reset(1'b0);
        chk_word("io_oe reloaded", exp_ram[0], io_oe);
        chk_bit("seq_run reloaded", 1'b1, seq_run);
        read_chk(4'h7, exp_ram[7]);
    endtask

    task automatic t_image();
        logic [15:0] old;
        old = exp_ram[4];
        exp_ram[4] = 16'habcd;
        host_u.send(OP_FLASH_WR, 4'h4, 16'habcd, 2);
        host_u.send(OP_FLASH_WR, 4'hf, ram_sum(), 0);
        read_chk(4'h4, old);
        chk_bit("seq_run image", 1'b1, seq_run);
        do_reset(1'b0);
        read_chk(4'h4, 16'habcd);
        chk_bit("cfg_bad good", 1'b0, cfg_bad);
    endtask

    task automatic t_bad();
        host_u.send(OP_FLASH_WR, 4'h6, 16'h5555, 0);
        do_reset(1'b0);
        chk_bit("cfg_bad", 1'b1, cfg_bad);
        chk_bit("alert_oe", 1'b1, alert_oe);
        chk_bit("alert_o", 1'b0, alert_o);
        chk_bit("seq_run bad", 1'b0, seq_run);
        chk_word("io_oe bad", 16'h0000, io_oe);
        // Wipe runs for one pass over RAM before commands are taken
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        read_chk(4'h6, 16'h0000);
    endtask

    task automatic t_tap();
        @(posedge clk_sys);
        tap_cfg_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("tap reject early", 1'b0, tap_cfg_reject);
        @(negedge clk_sys);
        chk_bit("tap reject", 1'b1, tap_cfg_reject);
        read_chk(4'h6, 16'h0000);
        @(posedge clk_sys);
        tap_cfg_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit("tap reject off", 1'b0, tap_cfg_reject);
    endtask

    // ************************************************************
    // Sequence and watchdog
    // ************************************************************
    initial begin
        t_factory();
        t_write();
        t_store();
        t_image();
        t_bad();
        t_tap();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end
endmodule
